// [core/dtd_pkg.sv]
// Purpose: constants, types and helpers of the tone decode and steering block
// Assumes: 20 MHz system clock, limited tone inputs synchronous to it
// Notes: all offsets, reset values and timing counts live here
//
// Notes on behaviour
// R1 - count tone periods, match standard tone frequencies
// R2 - early flag rises when both groups valid
// R3 - early flag falls on any loss of pair
// R4 - after present guard, latch the 4-bit code
// R5 - guard output high while registered and early
// R6 - code pins float unless host enables them
// R7 - delayed steering marks a registered valid digit
// R8 - short dropouts keep the latched code unchanged
// R9 - pairs shorter than recognition time are rejected
// R10 - present and absent guards set independently
// R11 - delayed steering drops after valid tone absence
// R12 - guard paths are clocked cycle counters
package dtd_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int RECOGNITION_TIME_MS = 40;
	localparam int TDP_MS = 8;
	localparam int TONE_PRESENT_GUARD_TIME_MS = RECOGNITION_TIME_MS - TDP_MS;
	localparam int TONE_ABSENT_GUARD_TIME_MS = 30;
	localparam int TONE_PRESENT_GUARD_TIME_CYCLES = TONE_PRESENT_GUARD_TIME_MS * (CLK_HZ / 1000);
	localparam int TONE_ABSENT_GUARD_TIME_CYCLES = TONE_ABSENT_GUARD_TIME_MS * (CLK_HZ / 1000);
	localparam int TOL_PERMILLE = 25;
	localparam int LO_HZ [4] = '{697, 770, 852, 941};
	localparam int HI_HZ [4] = '{1209, 1336, 1477, 1633};
	localparam int TONE_TIMEOUT_CYCLES = 2 * (CLK_HZ / LO_HZ[0]);
	localparam int PERIOD_W = 16;
	localparam int GUARD_W = 24;
	localparam int IRQ_W = 3;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PGUARD = 8'h04;
	localparam logic [7:0] ADDR_AGUARD = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;
	// interrupt bit positions
	localparam int IRQ_DIGIT = 0;
	localparam int IRQ_PAUSE = 1;
	localparam int IRQ_REJECT = 2;
	// status bit positions
	localparam int ST_EARLY = 0;
	localparam int ST_GUARD = 1;
	localparam int ST_DELAYED = 2;
	localparam int ST_LOW_OK = 3;
	localparam int ST_HIGH_OK = 4;
	localparam int ST_CODE_LSB = 8;
	// code per {row, column}
	localparam logic [3:0] CODE_TABLE [16] = '{
		4'h1, 4'h2, 4'h3, 4'hd, 4'h4, 4'h5, 4'h6, 4'he,
		4'h7, 4'h8, 4'h9, 4'hf, 4'hb, 4'ha, 4'hc, 4'h0};

	typedef enum logic [1:0] {S_IDLE, S_PRES, S_HELD, S_ABS} dtd_state_type;

	// returns {hit, index} for a measured period in clock cycles
	function automatic logic [2:0] tone_match(
		input logic [PERIOD_W-1:0] per,
		input logic high_grp);
		int p;
		int f;
		logic [2:0] res;
		res = 3'h0;
		for (int i = 0; i < 4; i++)
		begin
			f = high_grp ? HI_HZ[i] : LO_HZ[i];
			p = CLK_HZ / f;
			if (int'(per) >= p * (1000 - TOL_PERMILLE) / 1000 &&
				int'(per) <= p * (1000 + TOL_PERMILLE) / 1000)
				res = {1'b1, 2'(i)};
		end
		return res;
	endfunction: tone_match

	function automatic logic [3:0] pair_code(
		input logic [1:0] row,
		input logic [1:0] col);
		return CODE_TABLE[{row, col}];
	endfunction: pair_code
endpackage: dtd_pkg

// [core/dtd_steer_if.sv]
// Purpose: link between decode control and the steering timer
// Assumes: one clock domain
// Notes: pulses are combinational from the timer state
`timescale 1ns/100ps
interface dtd_steer_if;
	logic early;
	logic [dtd_pkg::GUARD_W-1:0] present_guard;
	logic [dtd_pkg::GUARD_W-1:0] absent_guard;
	logic reg_pulse;
	logic reject_pulse;
	logic pause_pulse;
	logic guard;
	logic delayed;
	modport ctrl (output early, present_guard, absent_guard,
		input reg_pulse, reject_pulse, pause_pulse, guard, delayed);
	modport steer (input early, present_guard, absent_guard,
		output reg_pulse, reject_pulse, pause_pulse, guard, delayed);
endinterface: dtd_steer_if

// [core/dtd_tone_meter.sv]
// Purpose: period counter and frequency classifier for one tone group
// Assumes: tone_in is a limited square wave synchronous to sys_clk
// Notes: two matching periods in a row are needed before valid rises
`timescale 1ns/100ps
module dtd_tone_meter #(
	parameter logic HIGH_GRP = 1'b0,
	parameter int TIMEOUT_CYCLES = dtd_pkg::TONE_TIMEOUT_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// tone in, class out
	input wire logic tone_in,
	output logic tone_valid,
	output logic [1:0] tone_idx
);
	logic tone_d_reg;
	logic [dtd_pkg::PERIOD_W-1:0] per_reg;
	logic [2:0] last_reg;
	logic valid_reg;

	// edge, period and classification
	wire logic rise = tone_in & ~tone_d_reg;
	wire logic [dtd_pkg::PERIOD_W-1:0] per_inc = per_reg + 1'b1;
	wire logic [2:0] hit = dtd_pkg::tone_match(per_inc, HIGH_GRP); // R1
	wire logic same = hit[2] & last_reg[2] & (hit[1:0] == last_reg[1:0]);
	wire logic timeout = per_reg == dtd_pkg::PERIOD_W'(TIMEOUT_CYCLES);

	// period counting between rising edges
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			tone_d_reg <= 1'b0;
			per_reg <= '0;
			last_reg <= 3'h0;
			valid_reg <= 1'b0;
		end
		else
		begin
			tone_d_reg <= tone_in;
			if (rise)
			begin
				per_reg <= '0;
				last_reg <= hit;
				valid_reg <= same; // R1
			end
			else if (timeout)
			begin
				last_reg <= 3'h0;
				valid_reg <= 1'b0;
			end
			else
				per_reg <= per_inc;
		end
	end

	assign tone_valid = valid_reg;
	assign tone_idx = last_reg[1:0];
endmodule: dtd_tone_meter

// [core/dtd_steer.sv]
// Purpose: digital stand-in for the external steering time constant
// Assumes: early flag is registered in the control module
// Notes: guard counts of zero act like one
`timescale 1ns/100ps
module dtd_steer (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// link to control
	dtd_steer_if.steer st
);
	dtd_pkg::dtd_state_type state_reg;
	dtd_pkg::dtd_state_type state_next;
	logic [dtd_pkg::GUARD_W-1:0] cnt_reg;
	logic [dtd_pkg::GUARD_W-1:0] cnt_next;
	logic delayed_reg;
	logic delayed_next;

	// counter compare against the two guards
	wire logic [dtd_pkg::GUARD_W-1:0] cnt_inc = cnt_reg + 1'b1;
	wire logic pres_done = cnt_inc >= st.present_guard; // R12
	wire logic abs_done = cnt_inc >= st.absent_guard; // R12
	wire logic in_pres = state_reg == dtd_pkg::S_PRES;
	wire logic in_abs = state_reg == dtd_pkg::S_ABS;
	wire logic in_held = state_reg == dtd_pkg::S_HELD;

	// timer sequencing
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		delayed_next = delayed_reg;
		unique case (state_reg)
			dtd_pkg::S_IDLE:
				if (st.early)
				begin
					state_next = dtd_pkg::S_PRES;
					cnt_next = '0;
				end
			dtd_pkg::S_PRES:
				if (!st.early)
					state_next = dtd_pkg::S_IDLE; // R9
				else if (pres_done)
				begin
					state_next = dtd_pkg::S_HELD;
					delayed_next = 1'b1; // R7
				end
				else
					cnt_next = cnt_inc;
			dtd_pkg::S_HELD:
				if (!st.early)
				begin
					state_next = dtd_pkg::S_ABS;
					cnt_next = '0;
				end
			dtd_pkg::S_ABS:
				if (st.early)
					state_next = dtd_pkg::S_HELD; // R8
				else if (abs_done)
				begin
					state_next = dtd_pkg::S_IDLE;
					delayed_next = 1'b0; // R11
				end
				else
					cnt_next = cnt_inc;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state_reg <= dtd_pkg::S_IDLE;
			cnt_reg <= '0;
			delayed_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			delayed_reg <= delayed_next;
		end
	end

	// event pulses and pin levels
	assign st.reg_pulse = in_pres & st.early & pres_done; // R4
	assign st.reject_pulse = in_pres & ~st.early; // R9
	assign st.pause_pulse = in_abs & ~st.early & abs_done; // R8
	assign st.guard = (in_held | in_abs) & st.early; // R5
	assign st.delayed = delayed_reg;
endmodule: dtd_steer

// [core/dtd_top.sv]
// Purpose: tone pair decode, steering and latched code bus with ahb-lite
// Assumes: single master, zero wait state slave, word accesses only
// Notes: haddr[7:0] decoded, upper bits alias
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module dtd_top #(
	parameter int PRESENT_GUARD_RST = dtd_pkg::TONE_PRESENT_GUARD_TIME_CYCLES,
	parameter int ABSENT_GUARD_RST = dtd_pkg::TONE_ABSENT_GUARD_TIME_CYCLES,
	parameter int TONE_TIMEOUT = dtd_pkg::TONE_TIMEOUT_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// limited tone streams
	input wire logic low_tone_in,
	input wire logic high_tone_in,
	// code bus
	input wire logic code_output_enable,
	output logic [3:0] tone_code_outputs,
	output logic [3:0] tone_code_oe,
	// steering pins and interrupt
	output logic early_steering_flag,
	output logic guard_output,
	output logic delayed_steering_output,
	output logic irq
);
	localparam int GW = dtd_pkg::GUARD_W;
	localparam int IW = dtd_pkg::IRQ_W;

	dtd_steer_if st_if ();

	logic lo_valid;
	logic hi_valid;
	logic [1:0] lo_idx;
	logic [1:0] hi_idx;
	logic early_reg;
	logic [3:0] code_reg;
	logic ctrl_en_reg;
	logic [GW-1:0] pguard_reg;
	logic [GW-1:0] aguard_reg;
	logic [IW-1:0] irq_stat_reg;
	logic [IW-1:0] irq_stat_next;
	logic [IW-1:0] irq_en_reg;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [31:0] hrdata_reg;

	// frequency meters for both groups
	dtd_tone_meter #(
		.HIGH_GRP(1'b0),
		.TIMEOUT_CYCLES(TONE_TIMEOUT)
	) u_low (
		.sys_clk(sys_clk),
		.srst(srst),
		.tone_in(low_tone_in),
		.tone_valid(lo_valid),
		.tone_idx(lo_idx)
	);

	dtd_tone_meter #(
		.HIGH_GRP(1'b1),
		.TIMEOUT_CYCLES(TONE_TIMEOUT)
	) u_high (
		.sys_clk(sys_clk),
		.srst(srst),
		.tone_in(high_tone_in),
		.tone_valid(hi_valid),
		.tone_idx(hi_idx)
	);

	// steering timer
	dtd_steer u_steer (
		.sys_clk(sys_clk),
		.srst(srst),
		.st(st_if.steer)
	);

	// pair decode and steering inputs
	wire logic pair_ok = ctrl_en_reg & lo_valid & hi_valid;
	wire logic [3:0] pair_code_w = dtd_pkg::pair_code(lo_idx, hi_idx);
	assign st_if.early = early_reg;
	assign st_if.present_guard = pguard_reg; // R10
	assign st_if.absent_guard = aguard_reg; // R10

	// early flag follows the pair condition
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			early_reg <= 1'b0;
		else
			early_reg <= pair_ok; // R2 R3
	end

	// output latch changes only on registration
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			code_reg <= 4'h0;
		else if (st_if.reg_pulse)
			code_reg <= pair_code_w; // R4
	end

	// bus address phase decode
	wire logic addr_take = hsel & hready & htrans[1];
	wire logic rd_take = addr_take & ~hwrite;
	wire logic [7:0] ra = haddr[7:0];
	wire logic wr_now = wr_pend_reg & hready;
	wire logic wr_ctrl = wr_now & (wr_addr_reg == dtd_pkg::ADDR_CTRL);
	wire logic wr_pg = wr_now & (wr_addr_reg == dtd_pkg::ADDR_PGUARD);
	wire logic wr_ag = wr_now & (wr_addr_reg == dtd_pkg::ADDR_AGUARD);
	wire logic wr_clr = wr_now & (wr_addr_reg == dtd_pkg::ADDR_IRQ_CLR);
	wire logic wr_ien = wr_now & (wr_addr_reg == dtd_pkg::ADDR_IRQ_EN);

	// status word of live state
	wire logic [31:0] status_w = {20'h0, code_reg, 3'h0,
		hi_valid, lo_valid, st_if.delayed, st_if.guard, early_reg};

	// read selection, unmapped reads zero
	wire logic [31:0] rd_data_next =
		(ra == dtd_pkg::ADDR_CTRL) ? {31'h0, ctrl_en_reg} :
		(ra == dtd_pkg::ADDR_PGUARD) ? {8'h0, pguard_reg} :
		(ra == dtd_pkg::ADDR_AGUARD) ? {8'h0, aguard_reg} :
		(ra == dtd_pkg::ADDR_STATUS) ? status_w :
		(ra == dtd_pkg::ADDR_IRQ_STAT) ? {29'h0, irq_stat_reg} :
		(ra == dtd_pkg::ADDR_IRQ_EN) ? {29'h0, irq_en_reg} :
		32'h0;

	// data phase tracking
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend_reg <= addr_take & hwrite;
			wr_addr_reg <= ra;
		end
	end

	// read data registered for the data phase
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			hrdata_reg <= 32'h0;
		else if (hready)
			hrdata_reg <= rd_take ? rd_data_next : 32'h0;
	end

	// control and guard registers
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			ctrl_en_reg <= dtd_pkg::CTRL_EN_RST;
			pguard_reg <= GW'(PRESENT_GUARD_RST);
			aguard_reg <= GW'(ABSENT_GUARD_RST);
			irq_en_reg <= dtd_pkg::IRQ_EN_RST;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_en_reg <= hwdata[0];
			if (wr_pg)
				pguard_reg <= hwdata[GW-1:0]; // R10
			if (wr_ag)
				aguard_reg <= hwdata[GW-1:0]; // R10
			if (wr_ien)
				irq_en_reg <= hwdata[IW-1:0];
		end
	end

	// sticky events, a new event beats a clear
	wire logic [IW-1:0] irq_set = {st_if.reject_pulse,
		st_if.pause_pulse, st_if.reg_pulse};
	wire logic [IW-1:0] irq_clr = wr_clr ? hwdata[IW-1:0] : 3'h0;
	assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			irq_stat_reg <= 3'h0;
		else
			irq_stat_reg <= irq_stat_next;
	end

	// pins and bus answers
	assign tone_code_oe = {4{code_output_enable}}; // R6
	assign tone_code_outputs = code_output_enable ? code_reg : 4'h0; // R6
	assign early_steering_flag = early_reg;
	assign guard_output = st_if.guard;
	assign delayed_steering_output = st_if.delayed;
	assign irq = |(irq_stat_reg & irq_en_reg);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	// run lengths of tone presence and absence, saturating
	logic [GW-1:0] pres_run;
	logic [GW-1:0] abs_run;
	always_ff @(posedge sys_clk)
	begin
		if (srst | ~early_reg)
			pres_run <= '0;
		else if (pres_run != '1)
			pres_run <= pres_run + 1'b1;
	end
	always_ff @(posedge sys_clk)
	begin
		if (srst | early_reg)
			abs_run <= '0;
		else if (abs_run != '1)
			abs_run <= abs_run + 1'b1;
	end

	default clocking dtd_cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	// early flag rises with the pair condition
	early_rise_a: assert property ( // R2
		pair_ok |=> early_steering_flag)
		else $error("early flag missed a valid pair");

	// early flag drops with any loss
	early_fall_a: assert property ( // R3
		!pair_ok |=> !early_steering_flag)
		else $error("early flag held without a pair");

	// latch loads the decoded pair
	latch_load_a: assert property ( // R4
		st_if.reg_pulse |=> code_reg == $past(pair_code_w))
		else $error("latched code differs from pair");

	// registration only after full present guard
	present_len_a: assert property ( // R9
		st_if.reg_pulse && pguard_reg != '0 |-> pres_run == pguard_reg)
		else $error("pair registered at wrong length");

	// guard output implies early flag
	guard_early_a: assert property ( // R5
		guard_output |-> early_steering_flag && delayed_steering_output)
		else $error("guard output without registered tone");

	// guard stays up while the flag stays up
	guard_hold_a: assert property ( // R5
		guard_output && pair_ok |=> guard_output)
		else $error("guard output dropped early");

	// code pins float while the host disables them
	code_float_a: assert property ( // R6
		!code_output_enable |-> tone_code_oe == 4'h0
			&& tone_code_outputs == 4'h0)
		else $error("code pins driven while disabled");

	// delayed steering follows registration
	delayed_on_a: assert property ( // R7
		st_if.reg_pulse |=> delayed_steering_output [*1] ##0
			irq_stat_reg[dtd_pkg::IRQ_DIGIT])
		else $error("delayed steering not raised");

	// latch unchanged without a registration
	latch_hold_a: assert property ( // R8
		!st_if.reg_pulse |=> $stable(code_reg))
		else $error("latch changed without registration");

	// pause only after full absent guard
	absent_len_a: assert property ( // R8
		st_if.pause_pulse && aguard_reg != '0 |-> abs_run == aguard_reg)
		else $error("pause accepted at wrong length");

	// delayed steering falls after the pause
	delayed_off_a: assert property ( // R11
		st_if.pause_pulse |=> !delayed_steering_output)
		else $error("delayed steering stuck after pause");

	// short dropout keeps delayed steering up
	dropout_a: assert property ( // R8
		delayed_steering_output && !st_if.pause_pulse
			|=> delayed_steering_output || $past(st_if.pause_pulse))
		else $error("dropout ended delayed steering");

	// main scenarios
	digit_c: cover property (st_if.reg_pulse);
	reject_c: cover property (st_if.reject_pulse);
	dropout_c: cover property (
		$fell(early_reg) && st_if.delayed ##[1:50] $rose(early_reg));
	pause_c: cover property (st_if.pause_pulse);
	bus_read_c: cover property (rd_take && ra == dtd_pkg::ADDR_STATUS);
endmodule: dtd_top

// [test/dtd_host_model.sv]
// Purpose: host model that reads the latched code after each digit
// Assumes: code pins float while code_oe is low
// Notes: read_delay picks a prompt or a slow read after each digit
`timescale 1ns/100ps
module dtd_host_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// device side
	input wire logic delayed,
	input wire logic [3:0] code,
	input wire logic [3:0] code_oe,
	input wire logic [3:0] read_delay,
	output logic code_output_enable,
	// what the host captured
	output logic [3:0] last_code,
	output logic [7:0] reads
);
	logic delayed_reg;
	logic [4:0] wait_reg;
	// one enable cycle per flagged digit, code taken at the closing edge
	always_ff @(posedge sys_clk)
	begin
		delayed_reg <= delayed;
		if (srst)
		begin
			code_output_enable <= 1'b0;
			wait_reg <= 5'h0;
			reads <= 8'h0;
			last_code <= 4'h0;
		end
		else if (code_output_enable)
		begin
			// a floating bus is seen as the inverse of the last value
			last_code <= (code_oe == 4'hf) ? code : ~last_code;
			reads <= reads + 8'h1;
			code_output_enable <= 1'b0;
		end
		else if (delayed && !delayed_reg)
			wait_reg <= {1'b0, read_delay} + 5'h1;
		else if (wait_reg == 5'h1)
		begin
			code_output_enable <= 1'b1;
			wait_reg <= 5'h0;
		end
		else if (wait_reg != 5'h0)
			wait_reg <= wait_reg - 5'h1;
	end
endmodule: dtd_host_model

// [test/tb.sv]
// Purpose: self-checking bench of the tone decode and steering block
// Assumes: small guard counts, real tone periods at 20 MHz
// Notes: once tones are valid the enable bit steers the early flag fast
`timescale 1ns/100ps
module tb;
	localparam int PG = 20;
	localparam int AG = 15;
	localparam int HZ = dtd_pkg::CLK_HZ;
	// first valid pair needs about three low periods, the tone swap two
	localparam int LIMIT = 100000;
	logic sys_clk, srst, hsel, hwrite, hreadyout, hresp, irq;
	wire logic hready;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic low_tone_in, high_tone_in, code_output_enable;
	logic [3:0] tone_code_outputs, tone_code_oe, last_code, rd_delay;
	logic early_steering_flag, guard_output, delayed_steering_output;
	logic lo_on, hi_on;
	logic [7:0] reads;
	int lo_per, hi_per, lo_cnt, hi_cnt, cycles, errors, checked;
	assign hready = hreadyout;
	dtd_top #(.PRESENT_GUARD_RST(PG), .ABSENT_GUARD_RST(AG)) DUT (
		.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .low_tone_in(low_tone_in),
		.high_tone_in(high_tone_in), .code_output_enable(code_output_enable),
		.tone_code_outputs(tone_code_outputs), .tone_code_oe(tone_code_oe),
		.early_steering_flag(early_steering_flag),
		.guard_output(guard_output),
		.delayed_steering_output(delayed_steering_output), .irq(irq));
	dtd_host_model host (.sys_clk(sys_clk), .srst(srst),
		.delayed(delayed_steering_output), .code(tone_code_outputs),
		.code_oe(tone_code_oe), .read_delay(rd_delay),
		.code_output_enable(code_output_enable), .last_code(last_code),
		.reads(reads));
	// clock
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// square waves of the two tone groups; timeout counter
	always @(posedge sys_clk)
	begin
		lo_cnt <= (lo_cnt + 1 >= lo_per) ? 0 : lo_cnt + 1;
		hi_cnt <= (hi_cnt + 1 >= hi_per) ? 0 : hi_cnt + 1;
		low_tone_in <= lo_on && lo_cnt < lo_per / 2;
		high_tone_in <= hi_on && hi_cnt < hi_per / 2;
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			errors = errors + 1;
			complete_run();
		end
	end
	task complete_run;
		if (errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask: complete_run
	task check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checked = checked + 1;
		if (seen !== exp)
		begin
			errors = errors + 1;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask: check
	// one single ahb-lite transfer, entered right after a rising edge
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		@(posedge sys_clk);
		while (hready !== 1'b1) @(posedge sys_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge sys_clk);
		while (hready !== 1'b1) @(posedge sys_clk);
		rd = hrdata;
	endtask: xfer
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask: wr
	task rd_chk(input string name, input logic [7:0] a,
		input logic [31:0] exp);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		check(name, r, exp);
	endtask: rd_chk
	// bounded wait on a status bit read over the bus
	task poll_bit(input int b, input logic val, input int lim);
		logic [31:0] r;
		int n;
		n = 0;
		r = {32{~val}};
		while (r[b] !== val && n < lim)
		begin
			xfer(1'b0, dtd_pkg::ADDR_STATUS, 32'h0, r);
			n = n + 1;
		end
		check("status poll", {31'h0, r[b]}, {31'h0, val});
	endtask: poll_bit
	// bounded wait on early (0) or delayed (1)
	task wait_flag(input int which, input logic val, input int lim,
		input string name);
		int n;
		n = 0;
		while ((which == 0 ? early_steering_flag : delayed_steering_output)
			!== val && n < lim)
		begin
			@(posedge sys_clk);
			n = n + 1;
		end
		check(name, which == 0 ? early_steering_flag :
			delayed_steering_output, val);
	endtask: wait_flag
	task wait_reads(input logic [7:0] cnt);
		int n;
		n = 0;
		while (reads !== cnt && n < 30)
		begin
			@(posedge sys_clk);
			n = n + 1;
		end
		check("host reads", reads, cnt);
	endtask: wait_reads
	task test_reset_regs;
		rd_chk("ctrl", dtd_pkg::ADDR_CTRL, 32'h1);
		rd_chk("present guard", dtd_pkg::ADDR_PGUARD, PG);
		rd_chk("absent guard", dtd_pkg::ADDR_AGUARD, AG);
		rd_chk("irq enable", dtd_pkg::ADDR_IRQ_EN, 32'h0);
		rd_chk("irq clear reads 0", dtd_pkg::ADDR_IRQ_CLR, 32'h0);
		rd_chk("unmapped", 8'h1c, 32'h0);
		check("pins float", tone_code_oe, 4'h0);
		check("pins low", tone_code_outputs, 4'h0);
		check("bus okay", hresp, 1'b0);
	endtask: test_reset_regs
	task test_reject;
		wr(dtd_pkg::ADDR_IRQ_EN, 32'h7);
		wr(dtd_pkg::ADDR_CTRL, 32'h0);
		lo_on <= 1'b1;
		hi_on <= 1'b1;
		poll_bit(dtd_pkg::ST_LOW_OK, 1'b1, 35000);
		poll_bit(dtd_pkg::ST_HIGH_OK, 1'b1, 30000);
		check("early off", early_steering_flag, 1'b0);
		wr(dtd_pkg::ADDR_CTRL, 32'h1);
		wr(dtd_pkg::ADDR_CTRL, 32'h0);
		repeat (4) @(posedge sys_clk);
		check("early dropped", early_steering_flag, 1'b0);
		rd_chk("reject irq", dtd_pkg::ADDR_IRQ_STAT, 32'h4);
		rd_chk("latch kept", dtd_pkg::ADDR_STATUS, 32'h18);
		check("irq raised", irq, 1'b1);
		wr(dtd_pkg::ADDR_IRQ_CLR, 32'h7);
		@(posedge sys_clk);
		check("irq cleared", irq, 1'b0);
	endtask: test_reject
	task test_register;
		wr(dtd_pkg::ADDR_CTRL, 32'h1);
		wait_flag(0, 1'b1, 4, "early rise");
		repeat (PG - 3) @(posedge sys_clk);
		check("no digit yet", delayed_steering_output, 1'b0);
		wait_flag(1, 1'b1, 6, "digit flagged");
		check("guard high", guard_output, 1'b1);
		check("digit irq", irq, 1'b1);
		wait_reads(8'h1);
		check("code read", last_code, 4'hb);
		check("pins float again", tone_code_oe, 4'h0);
	endtask: test_register
	task test_dropout_pause;
		wr(dtd_pkg::ADDR_AGUARD, 32'd40);
		rd_chk("absent guard set", dtd_pkg::ADDR_AGUARD, 32'd40);
		wr(dtd_pkg::ADDR_CTRL, 32'h0);
		repeat (30) @(posedge sys_clk);
		check("guard follows early", guard_output, 1'b0);
		check("dropout held", delayed_steering_output, 1'b1);
		wr(dtd_pkg::ADDR_CTRL, 32'h1);
		wait_flag(0, 1'b1, 4, "early back");
		@(posedge sys_clk);
		check("guard back", guard_output, 1'b1);
		rd_chk("no pause irq", dtd_pkg::ADDR_IRQ_STAT, 32'h1);
		rd_chk("status held", dtd_pkg::ADDR_STATUS, 32'hb1f);
		wr(dtd_pkg::ADDR_CTRL, 32'h0);
		repeat (36) @(posedge sys_clk);
		check("pause pending", delayed_steering_output, 1'b1);
		wait_flag(1, 1'b0, 12, "pause validated");
		rd_chk("pause irq", dtd_pkg::ADDR_IRQ_STAT, 32'h3);
		wr(dtd_pkg::ADDR_IRQ_CLR, 32'h7);
	endtask: test_dropout_pause
	task test_second_digit;
		wr(dtd_pkg::ADDR_PGUARD, 32'd30);
		// a new high tone breaks the matching run, no long silence needed
		hi_per <= HZ / dtd_pkg::HI_HZ[2];
		poll_bit(dtd_pkg::ST_HIGH_OK, 1'b0, 20000);
		poll_bit(dtd_pkg::ST_HIGH_OK, 1'b1, 20000);
		rd_delay <= 4'h6;
		wr(dtd_pkg::ADDR_CTRL, 32'h1);
		wait_flag(0, 1'b1, 4, "early rise two");
		repeat (27) @(posedge sys_clk);
		check("longer guard", delayed_steering_output, 1'b0);
		wait_flag(1, 1'b1, 6, "second digit");
		wait_reads(8'h2);
		check("second code", last_code, 4'hc);
		wr(dtd_pkg::ADDR_CTRL, 32'h0);
		wait_flag(1, 1'b0, 50, "second pause");
		rd_chk("code kept", dtd_pkg::ADDR_STATUS, 32'hc18);
	endtask: test_second_digit
	// stimulus at time zero, reset, then the scenarios
	initial
	begin
		srst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		lo_on = 1'b0;
		hi_on = 1'b0;
		lo_per = HZ / dtd_pkg::LO_HZ[3];
		hi_per = HZ / dtd_pkg::HI_HZ[0];
		lo_cnt = 0;
		hi_cnt = 0;
		rd_delay = 4'h0;
		errors = 0;
		checked = 0;
		cycles = 0;
		low_tone_in = 1'b0;
		high_tone_in = 1'b0;
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		test_reset_regs();
		test_reject();
		test_register();
		test_dropout_pause();
		test_second_digit();
		complete_run();
	end
endmodule: tb
